// file: inc/sdr_regs.vh
// Functional notes
// - Internal active-low reset held until supply passes 2.4V, then interface released.
// - Master clock ratio 256fs, 512fs or 768fs detected automatically.
// - 128fs master clock is the high-rate case, up to 192kHz.
// - Oversampling 128x normally, 64x when master clock is 128fs.
// - Reduced power when master clock stops; all timing derived from master clock (the code runs everything on clk and counts the stop delay in clk cycles).
// - Power down 1.5us after master clock stops toggling.
// - Every serial word is sent and taken MSB first.
// - Style pin low: right-justified; high: one-bit-delayed left-justified, up to 24 bits.
// - Short words are zero-filled in the unused low bits.
// - Channel-select pulse of 4 bit clocks or fewer selects DSP framing.
// - In DSP framing style 0 selects late timing, style 1 early timing.
// - Packed framing of 32 or 48 bit clocks per frame accepted.
// - Exactly 16 bit clocks per frame half switches to 16-bit words.
// - Delayed left-justified framing accepts 16 to 24 bit words.
// - Delayed left-justified: MSB on second rising bit clock after select change.
// - Delayed left-justified: select low is left, high is right.
// - Right-justified: 24-bit word, LSB on rising edge before select change.
// - Right-justified: select high is left, low is right.
// - DSP: sync pulse then 16-bit left word then 16-bit right word.
// - Data line is time-multiplexed by channel select, which also marks word bounds.
// - Mute and stop conversion when frame ratio is off by more than 8 clocks.
// - Words wider than 24 bits keep the top 24 bits.
`ifndef SDR_REGS_VH
`define SDR_REGS_VH

`define SDR_WORD_W        24
`define SDR_WORD_W5       5'd24
`define SDR_DSP_MAX_BITS  10'd4
`define SDR_PACK16_BITS   10'd16
`define SDR_DSP_LAST_L    6'd15
`define SDR_DSP_LAST_R    6'd31
`define SDR_HALF_MAX      10'h3ff
`define SDR_RATIO_128     11'd128
`define SDR_RATIO_256     11'd256
`define SDR_RATIO_512     11'd512
`define SDR_RATIO_768     11'd768
`define SDR_RATIO_TOL     11'd8
`define SDR_MCNT_MAX      11'h7ff
`define SDR_CODE_128      2'd0
`define SDR_CODE_256      2'd1
`define SDR_CODE_512      2'd2
`define SDR_CODE_768      2'd3
`define SDR_CLK_PERIOD_NS 40
`define SDR_MCLK_STOP_NS  1500
`define SDR_MCLK_STOP_CYC ((`SDR_MCLK_STOP_NS + `SDR_CLK_PERIOD_NS - 1) / `SDR_CLK_PERIOD_NS)

`endif

// file: hw/sdr_sync.v
`timescale 1ns/1ns
module sdr_sync #(
  parameter W = 1
) (
  // Clock
  input  wire         clk,
  // Asynchronous levels in, retimed levels out
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] hold_q;

  // First stage feeds only the second stage
  always @(posedge clk) begin
    meta_q <= async_in;
    hold_q <= meta_q;
  end

  assign sync_out = hold_q;

endmodule // sdr_sync

// file: hw/sdr_receiver.v
`timescale 1ns/1ns
`include "sdr_regs.vh"
module sdr_receiver (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Supply monitor and master clock pins
  input  wire        supply_ok,
  input  wire        mclk_in,
  // Serial audio pins
  input  wire        bit_clock_in,
  input  wire        channel_select_in,
  input  wire        data_in,
  input  wire        format_sel,
  // Filter path side
  output reg  [23:0] left_word,
  output reg  [23:0] right_word,
  output reg         sample_valid,
  // Status
  output reg         power_on_reset_n,
  output reg         mute,
  output reg         convert_en,
  output reg         power_down,
  output reg         osr_64,
  output reg  [1:0]  mclk_ratio,
  output reg         dsp_mode,
  output reg         word16
);

  localparam integer STOP_CYC_I = `SDR_MCLK_STOP_CYC;
  localparam [7:0]   STOP_CYC   = STOP_CYC_I[7:0];

  // Pin retiming
  wire [5:0] pins_s;
  wire       s_mclk;
  wire       s_supply;
  wire       s_bck;
  wire       s_lrc;
  wire       s_din;
  wire       s_fmt;

  sdr_sync #(
    .W (6)
  ) u_sync (
    .clk      (clk),
    .async_in ({mclk_in, supply_ok, bit_clock_in, channel_select_in, data_in, format_sel}),
    .sync_out (pins_s)
  );

  assign s_mclk   = pins_s[5];
  assign s_supply = pins_s[4];
  assign s_bck    = pins_s[3];
  assign s_lrc    = pins_s[2];
  assign s_din    = pins_s[1];
  assign s_fmt    = pins_s[0];

  // Power-on reset: internal logic held until the supply monitor reports ready
  reg  por_q;
  wire rst_int;

  always @(posedge clk) begin
    if (srst) begin
      por_q <= 1'b0;
    end else begin
      por_q <= s_supply;
    end
  end

  assign rst_int = srst | ~por_q;

  // Edge detection on retimed clocks
  reg  mclk_prev_q;
  reg  bck_prev_q;
  wire mclk_rise;
  wire bck_rise;

  always @(posedge clk) begin
    if (rst_int) begin
      mclk_prev_q <= 1'b0;
      bck_prev_q  <= 1'b0;
    end else begin
      mclk_prev_q <= s_mclk;
      bck_prev_q  <= s_bck;
    end
  end

  assign mclk_rise = s_mclk & ~mclk_prev_q;
  assign bck_rise  = s_bck & ~bck_prev_q;

  // Frame tracking on bit clock rising edges
  reg  [9:0]  half_cnt_q;
  reg         lrc_prev_q;
  reg         prev16_q;
  reg         dsp_q;
  reg         pack16_q;
  reg  [23:0] shreg_q;
  wire        trans;
  wire        half16;
  wire        pack_now;
  wire        frame_start;

  assign trans       = bck_rise & (s_lrc != lrc_prev_q);
  assign half16      = (half_cnt_q == `SDR_PACK16_BITS);
  assign pack_now    = half16 & prev16_q;
  assign frame_start = trans & s_lrc;

  always @(posedge clk) begin
    if (rst_int) begin
      half_cnt_q <= 10'h000;
      lrc_prev_q <= 1'b0;
      prev16_q   <= 1'b0;
      dsp_q      <= 1'b0;
      pack16_q   <= 1'b0;
      shreg_q    <= 24'h000000;
    end else if (bck_rise) begin
      lrc_prev_q <= s_lrc;
      shreg_q    <= {shreg_q[22:0], s_din};
      if (trans) begin
        half_cnt_q <= 10'h001;
        prev16_q   <= half16;
        pack16_q   <= pack_now;
        if (lrc_prev_q) begin
          // Width of the high phase decides between DSP and normal framing
          dsp_q <= (half_cnt_q <= `SDR_DSP_MAX_BITS);
        end
      end else if (half_cnt_q != `SDR_HALF_MAX) begin
        half_cnt_q <= half_cnt_q + 10'h001;
      end
    end
  end

  // Delayed left-justified collector: starts on the second edge of a half
  reg  [23:0] acc_q;
  reg  [4:0]  acc_cnt_q;

  always @(posedge clk) begin
    if (rst_int) begin
      acc_q     <= 24'h000000;
      acc_cnt_q <= 5'd0;
    end else if (bck_rise) begin
      if (trans) begin
        acc_q     <= 24'h000000;
        acc_cnt_q <= 5'd0;
      end else if (acc_cnt_q != `SDR_WORD_W5) begin
        // Bits past 24 are dropped, keeping the top of the word
        acc_q     <= {acc_q[22:0], s_din};
        acc_cnt_q <= acc_cnt_q + 5'd1;
      end
    end
  end

  // Left-align a short word, zeros below it
  function [23:0] align_word;
    input [23:0] w;
    input [4:0]  n;
    reg   [4:0]  sh;
    begin
      sh         = `SDR_WORD_W5 - n;
      align_word = w << sh;
    end
  endfunction

  // Word completed at a select change (normal framings)
  reg  [23:0] norm_word;
  reg         norm_left;

  always @* begin
    norm_word = 24'h000000;
    norm_left = 1'b0;
    if (s_fmt) begin
      // Packed 16-bit: the LSB lands on the first edge of the next half
      if (pack_now) begin
        norm_word = {acc_q[14:0], s_din, 8'h00};
      end else begin
        norm_word = align_word(acc_q, acc_cnt_q);
      end
      norm_left = ~lrc_prev_q;
    end else begin
      // LSB was taken on the edge before this change
      if (pack_now) begin
        norm_word = {shreg_q[15:0], 8'h00};
      end else begin
        norm_word = shreg_q;
      end
      norm_left = lrc_prev_q;
    end
  end

  // DSP collector: counts 32 bits from the sync edge (early timing) or from the edge after it (late)
  reg  [5:0] dsp_cnt_q;
  reg        dsp_act_q;
  wire       dsp_sync;

  assign dsp_sync = dsp_q & frame_start;

  always @(posedge clk) begin
    if (rst_int) begin
      dsp_cnt_q <= 6'd0;
      dsp_act_q <= 1'b0;
    end else if (bck_rise) begin
      if (dsp_sync) begin
        dsp_act_q <= 1'b1;
        // Early timing takes the MSB on the sync edge itself
        dsp_cnt_q <= s_fmt ? 6'd1 : 6'd0;
      end else if (dsp_act_q) begin
        dsp_cnt_q <= dsp_cnt_q + 6'd1;
        if (dsp_cnt_q == `SDR_DSP_LAST_R) begin
          dsp_act_q <= 1'b0;
        end
      end
    end
  end

  // Word events from either framing
  reg        word_done;
  reg        word_left;
  reg [23:0] word_val;

  always @* begin
    word_done = 1'b0;
    word_left = 1'b0;
    word_val  = 24'h000000;
    if (bck_rise) begin
      if (dsp_q) begin
        if (dsp_act_q && !dsp_sync && dsp_cnt_q == `SDR_DSP_LAST_L) begin
          word_done = 1'b1;
          word_left = 1'b1;
          word_val  = {shreg_q[14:0], s_din, 8'h00};
        end else if (dsp_act_q && !dsp_sync && dsp_cnt_q == `SDR_DSP_LAST_R) begin
          word_done = 1'b1;
          word_val  = {shreg_q[14:0], s_din, 8'h00};
        end
      end else if (trans) begin
        word_done = 1'b1;
        word_left = norm_left;
        word_val  = norm_word;
      end
    end
  end

  // Master clock ratio per frame and stop detection
  reg  [10:0] mcnt_q;
  reg  [7:0]  idle_q;
  reg         ratio_ok_q;
  reg  [1:0]  ratio_q;
  reg  [2:0]  ratio_chk;

  function near;
    input [10:0] c;
    input [10:0] r;
    begin
      near = (c + `SDR_RATIO_TOL >= r) && (c <= r + `SDR_RATIO_TOL);
    end
  endfunction

  always @* begin
    ratio_chk = 3'b000;
    if (near(mcnt_q, `SDR_RATIO_128)) begin
      ratio_chk = {1'b1, `SDR_CODE_128};
    end else if (near(mcnt_q, `SDR_RATIO_256)) begin
      ratio_chk = {1'b1, `SDR_CODE_256};
    end else if (near(mcnt_q, `SDR_RATIO_512)) begin
      ratio_chk = {1'b1, `SDR_CODE_512};
    end else if (near(mcnt_q, `SDR_RATIO_768)) begin
      ratio_chk = {1'b1, `SDR_CODE_768};
    end
  end

  always @(posedge clk) begin
    if (rst_int) begin
      mcnt_q     <= 11'd0;
      idle_q     <= 8'd0;
      ratio_ok_q <= 1'b0;
      ratio_q    <= `SDR_CODE_256;
    end else begin
      if (mclk_rise) begin
        idle_q <= 8'd0;
      end else if (idle_q != STOP_CYC) begin
        idle_q <= idle_q + 8'd1;
      end
      if (frame_start) begin
        mcnt_q <= mclk_rise ? 11'd1 : 11'd0;
        // Out of tolerance keeps the previous code but drops the ok flag
        ratio_ok_q <= ratio_chk[2];
        if (ratio_chk[2]) begin
          ratio_q <= ratio_chk[1:0];
        end
      end else begin
        if (mclk_rise && mcnt_q != `SDR_MCNT_MAX) begin
          mcnt_q <= mcnt_q + 11'd1;
        end
        if (idle_q == STOP_CYC) begin
          ratio_ok_q <= 1'b0;
        end
      end
    end
  end

  // Pairing and output registers
  reg  [23:0] left_hold_q;
  wire        run;

  assign run = ratio_ok_q & (idle_q != STOP_CYC);

  always @(posedge clk) begin
    if (rst_int) begin
      left_hold_q      <= 24'h000000;
      left_word        <= 24'h000000;
      right_word       <= 24'h000000;
      sample_valid     <= 1'b0;
      power_on_reset_n <= 1'b0;
      mute             <= 1'b1;
      convert_en       <= 1'b0;
      power_down       <= 1'b0;
      osr_64           <= 1'b0;
      mclk_ratio       <= `SDR_CODE_256;
      dsp_mode         <= 1'b0;
      word16           <= 1'b0;
    end else begin
      power_on_reset_n <= 1'b1;
      sample_valid     <= 1'b0;
      if (word_done && word_left) begin
        left_hold_q <= word_val;
      end
      // Right word closes the pair; nothing is passed while conversion is off
      if (word_done && !word_left && run) begin
        left_word    <= left_hold_q;
        right_word   <= word_val;
        sample_valid <= 1'b1;
      end
      mute       <= ~run;
      convert_en <= run;
      power_down <= (idle_q == STOP_CYC);
      osr_64     <= (ratio_q == `SDR_CODE_128);
      mclk_ratio <= ratio_q;
      dsp_mode   <= dsp_q;
      word16     <= pack16_q | dsp_q;
    end
  end

endmodule // sdr_receiver

// file: bench/sdr_receiver_monitor.sv
`timescale 1ns/1ns
module sdr_receiver_monitor (
  // Clock and reset
  input wire        clk,
  input wire        srst,
  // Pins watched
  input wire        supply_ok,
  input wire        mclk_in,
  // Outputs watched
  input wire [23:0] left_word,
  input wire [23:0] right_word,
  input wire        sample_valid,
  input wire        power_on_reset_n,
  input wire        mute,
  input wire        convert_en,
  input wire        power_down,
  input wire        osr_64,
  input wire [1:0]  mclk_ratio,
  input wire        dsp_mode,
  input wire        word16
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Raw pin idle time; the design's sync delay is absorbed by the window
  reg [5:0] idle_q;
  reg       mclk_q;
  always @(posedge clk) begin
    mclk_q <= mclk_in;
    if (srst || (mclk_in && !mclk_q)) idle_q <= 6'd0;
    else if (idle_q != 6'h3f) idle_q <= idle_q + 6'd1;
  end
  chk_valid_pulse: assert property (sample_valid |=> !sample_valid)
    else $error("valid strobe longer than one cycle");
  chk_words_hold: assert property (disable iff (srst || !power_on_reset_n)
    !($stable(left_word) && $stable(right_word)) |-> sample_valid)
    else $error("words changed without valid strobe");
  chk_mute_inv: assert property (convert_en == !mute)
    else $error("conversion enable not inverse of mute");
  chk_no_pair_muted: assert property (sample_valid |-> convert_en)
    else $error("pair delivered while muted");
  chk_osr_ratio: assert property (!mute |-> osr_64 == (mclk_ratio == 2'd0))
    else $error("oversampling flag disagrees with ratio");
  chk_pd_mute: assert property (power_down |-> mute)
    else $error("powered down without mute");
  chk_pd_late: assert property ($rose(power_down) |-> idle_q >= 6'd36 && idle_q <= 6'd46)
    else $error("power down at wrong idle time");
  chk_pd_missing: assert property (idle_q == 6'd50 |-> power_down)
    else $error("no power down after master clock stop");
  chk_por_supply: assert property ($fell(supply_ok) |-> ##[1:5] !power_on_reset_n)
    else $error("supply drop did not reset");
  chk_por_release: assert property ($fell(srst) |-> !power_on_reset_n && mute
    && mclk_ratio == 2'd1)
    else $error("reset state wrong");
  chk_dsp_short: assert property (dsp_mode |-> word16)
    else $error("DSP framing without 16-bit words");
endmodule // sdr_receiver_monitor

bind sdr_receiver sdr_receiver_monitor sdr_receiver_monitor_i (
  .clk(clk), .srst(srst), .supply_ok(supply_ok), .mclk_in(mclk_in),
  .left_word(left_word), .right_word(right_word), .sample_valid(sample_valid),
  .power_on_reset_n(power_on_reset_n), .mute(mute), .convert_en(convert_en),
  .power_down(power_down), .osr_64(osr_64), .mclk_ratio(mclk_ratio),
  .dsp_mode(dsp_mode), .word16(word16));

// file: bench/sdr_source.sv
`timescale 1ns/1ns
module sdr_source (
  // Controls
  input  wire        run,
  input  wire        mclk_on,
  input  wire [1:0]  mode,
  input  wire        fmt,
  input  wire        pk,
  input  wire [5:0]  wl,
  input  wire [23:0] lw,
  input  wire [23:0] rw,
  input  wire [7:0]  mclk_half,
  // Pins
  output reg         mclk,
  output reg         bclk,
  output reg         sel,
  output reg         din,
  output reg         fstart
);
  integer    i, p, hw, hl, w, b, k;
  reg [23:0] word [0:2];
  initial begin
    mclk = 0; bclk = 0; sel = 0; din = 0; fstart = 0;
  end
  // Held mclk level when stopped; ratio kept by half period
  always begin
    if (mclk_half > 0) #(mclk_half);
    else #10;
    if (mclk_on) mclk = ~mclk;
  end
  // Mode 0 right-justified, 1 delayed LJ, 2 DSP; 64 bit clocks a frame, 32 packed
  always begin
    if (!run) #40;
    else begin
      word[2] = word[1];
      word[0] = lw;
      word[1] = rw;
      fstart = ~fstart;
      hl = pk ? 16 : 32;
      for (i = 0; i < 2 * hl; i = i + 1) begin
        hw = (mode == 2) ? 16 : hl;
        p = (mode == 2) ? i - !fmt : (mode == 1) ? i - 1 : i;
        // Delayed LJ: the last right bit falls on the first edge of the next frame
        w = (p < 0 && mode == 1) ? 2 : p / hw;
        b = (p < 0 && mode == 1) ? hw - 1 : p % hw;
        k = b + wl - hl;
        sel = (mode == 2) ? (i == 0) : (mode == 1) ? (i >= hl) : (i < hl);
        if (mode == 0) din = (k >= 0 && k < 24) ? word[w][23 - k] : b[0];
        else if ((w == 2 || (p >= 0 && w < 2)) && b < wl)
          din = (b < 24) ? word[w][23 - b] : b[0];
        else din = 1'b0;
        #160 bclk = 1;
        #160 bclk = 0;
      end
    end
  end
endmodule // sdr_source

// file: bench/test_sdr_receiver.sv
`timescale 1ns/1ns
module test_sdr_receiver;
  reg         clk, srst, supply_ok, fmt, run, mclk_on, armed, pk;
  reg  [1:0]  mode;
  reg  [5:0]  wl;
  reg  [23:0] lw, rw;
  reg  [7:0]  mh;
  reg  [31:0] lfsr;
  reg  [47:0] q [$];
  wire        mclk, bclk, sel, din, fs, sample_valid, power_on_reset_n, mute;
  wire        convert_en, power_down, osr_64, dsp_mode, word16;
  wire [23:0] left_word, right_word;
  wire [1:0]  mclk_ratio;
  integer     miscompares, check_count, cycles, nv, n;
  sdr_receiver sdr_receiver_i (.clk(clk), .srst(srst), .supply_ok(supply_ok),
    .mclk_in(mclk), .bit_clock_in(bclk), .channel_select_in(sel), .data_in(din),
    .format_sel(fmt), .left_word(left_word), .right_word(right_word),
    .sample_valid(sample_valid), .power_on_reset_n(power_on_reset_n), .mute(mute),
    .convert_en(convert_en), .power_down(power_down), .osr_64(osr_64),
    .mclk_ratio(mclk_ratio), .dsp_mode(dsp_mode), .word16(word16));
  sdr_source sdr_source_i (.run(run), .mclk_on(mclk_on), .mode(mode), .fmt(fmt), .pk(pk), .wl(wl),
    .lw(lw), .rw(rw), .mclk_half(mh), .mclk(mclk), .bclk(bclk), .sel(sel), .din(din),
    .fstart(fs));
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [23:0] msk(input [5:0] n);
    msk = (n >= 24) ? 24'hffffff : 24'hffffff << (24 - n);
  endfunction
  task check(input [47:0] seen, input [47:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  // Early frames after a change are skipped: detection needs a frame to settle
  task frames(input [1:0] md, input f, input [5:0] w, input pw);
    begin
      @(negedge clk);
      mode = md; fmt = f; wl = w; pk = pw; armed = 0;
      // Packed frames are half as long, so mclk runs twice as fast to stay at 128fs
      mh = pw ? 8'd40 : 8'd80;
      repeat (4) @(fs);
      nv = 0; armed = 1;
      repeat (4) @(fs);
      @(negedge clk);
      armed = 0;
      check(nv >= 3, 1);
      check(dsp_mode, md == 2'd2);
      check(word16, md == 2'd2 || pw);
      check({mute, convert_en, osr_64, mclk_ratio}, 5'b01100);
      $display("test mode %0d fmt %0d width %0d packed %0d done", md, f, w, pw);
    end
  endtask
  initial clk = 0;
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 60000) begin
      miscompares = miscompares + 1;
      close_out;
    end
  end
  always @(fs) begin
    q.push_back({lw & msk(wl), rw & msk(wl)});
    @(negedge clk);
    lfsr = nxt(lfsr); lw = lfsr[23:0];
    lfsr = nxt(lfsr); rw = lfsr[23:0];
  end
  // DSP pairs close mid-frame, the others at the next frame start
  always @(negedge clk) if (armed && sample_valid === 1'b1) begin
    nv = nv + 1;
    check({left_word, right_word}, q[q.size() - ((mode == 2) ? 1 : 2)]);
  end
  initial begin
    srst = 1; supply_ok = 1; run = 0; mclk_on = 1; mh = 80; mode = 1; fmt = 1; wl = 24;
    lfsr = 32'h8378240d; lw = 24'h000000; rw = 24'h000000; armed = 0; pk = 0;
    miscompares = 0; check_count = 0; cycles = 0; nv = 0;
    repeat (12) @(negedge clk);
    check({mute, mclk_ratio, power_on_reset_n, sample_valid}, 5'b10100);
    srst = 0;
    repeat (8) @(negedge clk);
    run = 1;
    frames(2'd1, 1, 24, 0);
    frames(2'd1, 1, 20, 0);
    frames(2'd1, 1, 16, 0);
    frames(2'd1, 1, 32, 0);
    frames(2'd1, 1, 16, 1);
    frames(2'd0, 0, 24, 0);
    frames(2'd0, 0, 16, 1);
    frames(2'd2, 0, 16, 0);
    frames(2'd2, 1, 16, 0);
    frames(2'd1, 1, 24, 0);
    mh = 120;
    repeat (3) @(fs);
    @(negedge clk);
    check({mute, convert_en}, 2'b10);
    mh = 40;
    repeat (3) @(fs);
    @(negedge clk);
    check({mute, convert_en, osr_64, mclk_ratio}, 5'b01001);
    mh = 80;
    repeat (3) @(fs);
    @(negedge mclk);
    mclk_on = 0;
    n = 0;
    while (power_down !== 1'b1 && n < 80) begin
      @(negedge clk);
      n = n + 1;
    end
    check(n >= 34 && n <= 44, 1);
    check(mute, 1);
    mclk_on = 1;
    @(negedge clk);
    supply_ok = 0;
    repeat (5) @(negedge clk);
    check(power_on_reset_n, 0);
    supply_ok = 1;
    repeat (8) @(negedge clk);
    check(power_on_reset_n, 1);
    $display("test power and reset done");
    close_out;
  end
endmodule // test_sdr_receiver
